/* cmsq_pkg.sv */
// package: register map, timing counts, types for the conversion sequencer
package cmsq_pkg;
    // register byte offsets
    localparam logic [5:0] ADDR_STATUS    = 6'h00;
    localparam logic [5:0] ADDR_AUX_RES   = 6'h01;  // aux result pair, msb first
    localparam logic [5:0] ADDR_CELL1_RES = 6'h03;  // cell 1 result pair, msb first
    localparam logic [5:0] ADDR_ADC_CTRL  = 6'h30;
    localparam logic [5:0] ADDR_IO_CTRL   = 6'h31;
    localparam logic [5:0] ADDR_SOFTWARE_START_BIT_CTRL = 6'h32;
    localparam logic [5:0] ADDR_FUNC_CFG  = 6'h33;
    // field positions
    localparam int         ADC_TS1_BIT    = 4;
    localparam int         ADC_TS2_BIT    = 5;
    localparam int         ADC_AUX_BIT    = 6;
    localparam int         ADC_ON_BIT     = 7;
    localparam int         SOFTWARE_START_BIT_START_BIT = 0;
    localparam int         FCFG_REF_BIT   = 0;      // aux reference: 1 = band-gap
    localparam int         FCFG_SRC_BIT   = 1;      // aux source: 1 = pack voltage
    // reset values
    localparam logic [7:0] ADC_CTRL_RST   = 8'h00;
    localparam logic [7:0] IO_CTRL_RST    = 8'h00;
    localparam logic [7:0] FUNC_CFG_RST   = 8'h00;
    // channel indices
    localparam int         NUM_CHAN       = 9;
    localparam logic [3:0] CH_TS1         = 4'h6;
    localparam logic [3:0] CH_TS2         = 4'h7;
    localparam logic [3:0] CH_AUX         = 4'h8;
    localparam logic [3:0] CH_NONE        = 4'hF;
    localparam logic [2:0] CELL_SEL_MAX   = 3'h5;
    // result coding
    localparam logic [13:0] CODE_MAX      = 14'h3FFF;
    localparam logic [15:0] TS1_OFFSET    = 16'h0002;
    localparam logic [15:0] TS2_OFFSET    = 16'h0009;
    // timing
    localparam int         CLK_PERIOD_NS  = 25;
    localparam int         T_SLOT_NS      = 6000;   // per channel and start overhead
    localparam int         T_SETTLE_NS    = 500000; // reference settling, converter off
    localparam int         SLOT_CYC       = (T_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         SETTLE_CYC     = (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // converter control register as fields
    typedef struct packed {
        logic       adc_on;
        logic       aux_en;
        logic       ts2_en;
        logic       ts1_en;
        logic       rsvd;
        logic [2:0] cell_sel;
    } cmsq_adc_ctrl_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETTLE,
        ST_OVERHEAD,
        ST_CONVERT,
        ST_FINISH
    } cmsq_state_t;
endpackage : cmsq_pkg

/* cmsq_sequencer.sv */
// conversion start, channel sequencing and result storage for the monitor adc
//
// Functional notes
// RL1 - aux band-gap result stored as scaled code
// RL2 - pack-voltage result stored as scaled code
// RL3 - thermistor codes clamped to 0..16383
// RL4 - thermistor enable adds channel next cycle
// RL5 - io bit closes thermistor ground switch
// RL6 - thermistor codes carry offsets 2 and 9
// RL7 - start pin rising edge starts cycle
// RL8 - host holds start pin until cycle ends
// RL9 - start pin forwarded upward at once (here registered after the two-flop synchroniser, three clocks late)
// RL10 - every enabled channel measured in turn
// RL11 - software start ignored while pin high
// RL12 - software start bit self-clears, write-one only
// RL13 - host broadcasts software start to stack
// RL14 - ready out needs last store and upward ready
// RL15 - ready out drops at next start
// RL16 - cell field selects cells 1..n+1
// RL17 - enable bits add thermistors and aux
// RL18 - 6 us per channel plus 6 us
// RL19 - power bit keeps converter and reference on
// RL20 - host waits 500 us after power bit
// RL21 - powered-down start adds 500 us settling
// RL22 - host uses manual mode below 10 ms
// RL23 - results big-endian, msb at lower address
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module cmsq_sequencer #(
    parameter int SETTLE_CYCLES = cmsq_pkg::SETTLE_CYC,  // shorten in simulation
    parameter int SLOT_CYCLES   = cmsq_pkg::SLOT_CYC
) (
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        nrst_in,
    // register port
    input  wire logic [5:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    // stack pins
    input  wire logic        host_start_pin_in,
    input  wire logic        south_start_pin_in,
    input  wire logic        upward_result_ready_in,
    input  wire logic        bottom_device_in,
    output logic             upward_start_out,
    output logic             host_result_ready_out,
    output logic             south_result_ready_out,
    // analog converter side
    input  wire logic [15:0] adc_raw_in,
    output logic      [3:0]  adc_chan_out,
    output logic             adc_sample_out,
    output logic             adc_power_out,
    output logic             aux_reference_select_out,
    output logic             aux_source_pack_out,
    output logic             ts1_gnd_switch_out,
    output logic             ts2_gnd_switch_out
);
    // refuse timing counts that the 15-bit phase counter cannot hold
    if (SETTLE_CYCLES < 2 || SETTLE_CYCLES > 32767 || SLOT_CYCLES < 2 || SLOT_CYCLES > 32767)
    begin : g_bad_timing
        $error("cmsq_sequencer: timing counts out of range");
    end

    // is channel ch part of the sequence under cfg
    function automatic logic chan_enabled(input logic [3:0] ch,
                                          input cmsq_pkg::cmsq_adc_ctrl_t cfg);
        logic [2:0] cells;
        cells = (cfg.cell_sel > cmsq_pkg::CELL_SEL_MAX) ? cmsq_pkg::CELL_SEL_MAX : cfg.cell_sel;
        if (ch < cmsq_pkg::CH_TS1)
            return ch[2:0] <= cells;                      // [RL16]
        else if (ch == cmsq_pkg::CH_TS1)
            return cfg.ts1_en;                            // [RL4] [RL17]
        else if (ch == cmsq_pkg::CH_TS2)
            return cfg.ts2_en;                            // [RL17]
        else if (ch == cmsq_pkg::CH_AUX)
            return cfg.aux_en;                            // [RL17]
        else
            return 1'b0;
    endfunction : chan_enabled

    // first enabled channel at or after from, or none
    function automatic logic [3:0] next_chan(input logic [3:0] from,
                                             input cmsq_pkg::cmsq_adc_ctrl_t cfg);
        logic [3:0] pick;
        pick = cmsq_pkg::CH_NONE;
        for (int i = cmsq_pkg::NUM_CHAN - 1; i >= 0; i--)
        begin
            if (4'(i) >= from && chan_enabled(4'(i), cfg))
                pick = 4'(i);
        end
        return pick;
    endfunction : next_chan

    // register address of the high byte for a channel
    function automatic logic [5:0] res_addr(input int ch);
        if (ch == int'(cmsq_pkg::CH_AUX))
            return cmsq_pkg::ADDR_AUX_RES;
        else
            return 6'(cmsq_pkg::ADDR_CELL1_RES + 6'(2 * ch));
    endfunction : res_addr

    // clamp raw converter value, minus offset, into 14 bits
    function automatic logic [13:0] clamp_code(input logic [15:0] raw, input logic [15:0] off);
        if (raw < off)
            return 14'h0000;
        else if ((raw - off) > {2'b00, cmsq_pkg::CODE_MAX})
            return cmsq_pkg::CODE_MAX;
        else
            return 14'(raw - off);
    endfunction : clamp_code

    // pin synchronisers: host start, south start, upward ready, bottom select
    logic [3:0]  pin_meta_q;                 // first stage, read only by sync stage
    logic [3:0]  pin_sync_q;                 // usable pin levels
    logic        start_lvl_q;                // previous selected start level
    // control registers
    cmsq_pkg::cmsq_adc_ctrl_t adc_ctrl_q;    // channel and power control
    cmsq_pkg::cmsq_adc_ctrl_t run_cfg_q;     // snapshot for the running cycle
    logic [7:0]  io_ctrl_q;                  // thermistor switch bits
    logic [7:0]  func_cfg_q;                 // aux reference and source
    logic        sw_start_q;                 // software start bit
    // sequencer
    cmsq_pkg::cmsq_state_t state_q;
    logic [14:0] tmr_q;                      // down counter for the current phase
    logic [3:0]  chan_q;                     // channel being converted
    logic        done_q;                     // last result stored, cycle ended
    logic [13:0] res_q [cmsq_pkg::NUM_CHAN]; // stored results

    // selected start pin and conditions
    logic        start_lvl;
    logic        hw_start;
    logic        sw_start;
    logic        start;
    logic        slot_end;
    logic        wr_software_start_bit;
    assign start_lvl = pin_sync_q[3] ? pin_sync_q[0] : pin_sync_q[1];
    assign hw_start  = start_lvl && !start_lvl_q && state_q == cmsq_pkg::ST_IDLE;   // [RL7]
    assign sw_start  = sw_start_q && !start_lvl && state_q == cmsq_pkg::ST_IDLE;    // [RL11]
    assign start     = hw_start || sw_start;
    assign slot_end  = tmr_q == 15'h0000;
    assign wr_software_start_bit   = reg_wr_in && reg_addr_in == cmsq_pkg::ADDR_SOFTWARE_START_BIT_CTRL;

    // two-flop synchronisers for all pins
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pin_meta_q  <= 4'h0;
            pin_sync_q  <= 4'h0;
            start_lvl_q <= 1'b0;
        end
        else
        begin
            pin_meta_q  <= {bottom_device_in, upward_result_ready_in,
                            south_start_pin_in, host_start_pin_in};
            pin_sync_q  <= pin_meta_q;
            start_lvl_q <= start_lvl;
        end
    end

    // control register writes
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            adc_ctrl_q <= cmsq_pkg::ADC_CTRL_RST;
            io_ctrl_q  <= cmsq_pkg::IO_CTRL_RST;
            func_cfg_q <= cmsq_pkg::FUNC_CFG_RST;
        end
        else if (reg_wr_in)
        begin
            case (reg_addr_in)
                cmsq_pkg::ADDR_ADC_CTRL: adc_ctrl_q <= reg_wdata_in;
                cmsq_pkg::ADDR_IO_CTRL:  io_ctrl_q  <= reg_wdata_in;
                cmsq_pkg::ADDR_FUNC_CFG: func_cfg_q <= reg_wdata_in;
                default:                 ;
            endcase
        end
    end

    // software start bit: write one sets, cycle end clears, set wins
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            sw_start_q <= 1'b0;
        else if (wr_software_start_bit && reg_wdata_in[cmsq_pkg::SOFTWARE_START_BIT_START_BIT])
            sw_start_q <= 1'b1;                           // [RL12]
        else if (state_q == cmsq_pkg::ST_FINISH)
            sw_start_q <= 1'b0;                           // [RL12]
    end

    // sequencer: settle, overhead slot, one slot per enabled channel
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_q   <= cmsq_pkg::ST_IDLE;
            tmr_q     <= 15'h0000;
            chan_q    <= cmsq_pkg::CH_NONE;
            run_cfg_q <= cmsq_pkg::ADC_CTRL_RST;
        end
        else
        begin
            case (state_q)
                cmsq_pkg::ST_IDLE:
                begin
                    if (start)
                    begin
                        run_cfg_q <= adc_ctrl_q;
                        if (!adc_ctrl_q.adc_on)
                        begin
                            state_q <= cmsq_pkg::ST_SETTLE;                // [RL21]
                            tmr_q   <= 15'(SETTLE_CYCLES - 1);
                        end
                        else
                        begin
                            state_q <= cmsq_pkg::ST_OVERHEAD;              // [RL19]
                            tmr_q   <= 15'(SLOT_CYCLES - 1);
                        end
                    end
                end
                cmsq_pkg::ST_SETTLE:
                begin
                    if (slot_end)
                    begin
                        state_q <= cmsq_pkg::ST_OVERHEAD;
                        tmr_q   <= 15'(SLOT_CYCLES - 1);                   // [RL18]
                    end
                    else
                        tmr_q <= tmr_q - 15'h0001;
                end
                cmsq_pkg::ST_OVERHEAD:
                begin
                    if (slot_end)
                    begin
                        state_q <= cmsq_pkg::ST_CONVERT;
                        chan_q  <= next_chan(4'h0, run_cfg_q);             // [RL10]
                        tmr_q   <= 15'(SLOT_CYCLES - 1);
                    end
                    else
                        tmr_q <= tmr_q - 15'h0001;
                end
                cmsq_pkg::ST_CONVERT:
                begin
                    if (slot_end)
                    begin
                        chan_q <= next_chan(chan_q + 4'h1, run_cfg_q);    // [RL10]
                        tmr_q  <= 15'(SLOT_CYCLES - 1);                    // [RL18]
                        if (next_chan(chan_q + 4'h1, run_cfg_q) == cmsq_pkg::CH_NONE)
                            state_q <= cmsq_pkg::ST_FINISH;
                    end
                    else
                        tmr_q <= tmr_q - 15'h0001;
                end
                cmsq_pkg::ST_FINISH:
                begin
                    state_q <= cmsq_pkg::ST_IDLE;
                    chan_q  <= cmsq_pkg::CH_NONE;
                end
                default:
                    state_q <= cmsq_pkg::ST_IDLE;
            endcase
        end
    end

    // result capture at the end of each channel slot
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            for (int i = 0; i < cmsq_pkg::NUM_CHAN; i++)
                res_q[i] <= 14'h0000;
        end
        else if (state_q == cmsq_pkg::ST_CONVERT && slot_end)
        begin
            case (chan_q)
                // thermistor codes: ratio times scale minus channel offset
                cmsq_pkg::CH_TS1: res_q[chan_q] <= clamp_code(adc_raw_in, cmsq_pkg::TS1_OFFSET);
                cmsq_pkg::CH_TS2: res_q[chan_q] <= clamp_code(adc_raw_in, cmsq_pkg::TS2_OFFSET);
                // aux: band-gap or pack scale is set by the converter front end
                default:          res_q[chan_q] <= clamp_code(adc_raw_in, 16'h0000); // [RL1] [RL2]
            endcase
        end
    end
    // thermistor offsets above apply both the clamp [RL3] and channel offset [RL6]

    // cycle done flag: set after last store, cleared by next start
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            done_q <= 1'b0;
        else if (start)
            done_q <= 1'b0;                               // [RL15]
        else if (state_q == cmsq_pkg::ST_FINISH)
            done_q <= 1'b1;                               // [RL14]
    end

    // pin outputs, all registered; the start pin path is three flops late
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            upward_start_out       <= 1'b0;
            host_result_ready_out  <= 1'b0;
            south_result_ready_out <= 1'b0;
        end
        else
        begin
            upward_start_out       <= start_lvl;                              // [RL9]
            host_result_ready_out  <= pin_sync_q[3] && done_q && !start
                                      && pin_sync_q[2];                        // [RL14]
            south_result_ready_out <= !pin_sync_q[3] && done_q && !start
                                      && pin_sync_q[2];                        // [RL14]
        end
    end

    // analog control outputs
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            adc_chan_out             <= cmsq_pkg::CH_NONE;
            adc_sample_out           <= 1'b0;
            adc_power_out            <= 1'b0;
            aux_reference_select_out <= 1'b0;
            aux_source_pack_out      <= 1'b0;
            ts1_gnd_switch_out       <= 1'b0;
            ts2_gnd_switch_out       <= 1'b0;
        end
        else
        begin
            adc_chan_out             <= chan_q;
            adc_sample_out           <= state_q == cmsq_pkg::ST_CONVERT && tmr_q == 15'h0001;
            // powered while the bit is set or any cycle runs [RL19]
            adc_power_out            <= adc_ctrl_q.adc_on || state_q != cmsq_pkg::ST_IDLE;
            aux_reference_select_out <= func_cfg_q[cmsq_pkg::FCFG_REF_BIT]
                                        || func_cfg_q[cmsq_pkg::FCFG_SRC_BIT];
            aux_source_pack_out      <= func_cfg_q[cmsq_pkg::FCFG_SRC_BIT];
            ts1_gnd_switch_out       <= io_ctrl_q[cmsq_pkg::ADC_TS1_BIT];     // [RL5]
            ts2_gnd_switch_out       <= io_ctrl_q[cmsq_pkg::ADC_TS2_BIT];     // [RL5]
        end
    end

    // register reads, data stand in the following cycle only
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            reg_rdata_out <= 8'h00;
        else if (!reg_rd_in)
            reg_rdata_out <= 8'h00;
        else
        begin
            reg_rdata_out <= 8'h00;                       // unmapped reads zero
            case (reg_addr_in)
                cmsq_pkg::ADDR_STATUS:
                    reg_rdata_out <= {4'h0, pin_sync_q[2], start_lvl, done_q,
                                      state_q != cmsq_pkg::ST_IDLE};
                cmsq_pkg::ADDR_ADC_CTRL:  reg_rdata_out <= adc_ctrl_q;
                cmsq_pkg::ADDR_IO_CTRL:   reg_rdata_out <= io_ctrl_q;
                cmsq_pkg::ADDR_FUNC_CFG:  reg_rdata_out <= func_cfg_q;
                cmsq_pkg::ADDR_SOFTWARE_START_BIT_CTRL: reg_rdata_out <= {7'h00, sw_start_q};
                default:
                begin
                    for (int i = 0; i < cmsq_pkg::NUM_CHAN; i++)
                    begin
                        if (reg_addr_in == res_addr(i))
                            reg_rdata_out <= {2'b00, res_q[i][13:8]};          // [RL23]
                        if (reg_addr_in == 6'(res_addr(i) + 6'h01))
                            reg_rdata_out <= res_q[i][7:0];                    // [RL23]
                    end
                end
            endcase
        end
    end

    // cycles spent in the overhead slot; a counter, since the slot can be long
    logic [14:0] ovh_cnt_q;
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            ovh_cnt_q <= 15'h0000;
        else if (state_q == cmsq_pkg::ST_OVERHEAD)
            ovh_cnt_q <= ovh_cnt_q + 15'h0001;
        else
            ovh_cnt_q <= 15'h0000;
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    sequence seq_hw_edge;
        state_q == cmsq_pkg::ST_IDLE && start_lvl && !start_lvl_q;
    endsequence
    sequence seq_slot_done;
        state_q == cmsq_pkg::ST_CONVERT && slot_end;
    endsequence

    pin_start_seq_a: assert property (seq_hw_edge |=> state_q != cmsq_pkg::ST_IDLE) // [RL7]
        else $error("start pin edge did not start a cycle");
    sw_ignored_a: assert property ( // [RL11]
        (state_q == cmsq_pkg::ST_IDLE && start_lvl && start_lvl_q)
        |=> state_q == cmsq_pkg::ST_IDLE)
        else $error("software start taken while pin high");
    sw_self_clear_a: assert property (state_q == cmsq_pkg::ST_FINISH && !wr_software_start_bit |=> !sw_start_q) // [RL12]
        else $error("software start bit not cleared at cycle end");
    start_forward_a: assert property (##1 upward_start_out == $past(start_lvl)) // [RL9]
        else $error("start not forwarded upward");
    ready_drop_a: assert property ( // [RL15]
        start |=> !done_q ##1 !host_result_ready_out && !south_result_ready_out)
        else $error("ready output not cleared on start");
    ready_gate_a: assert property ( // [RL14]
        host_result_ready_out || south_result_ready_out
        |-> $past(done_q) && $past(pin_sync_q[2]))
        else $error("ready output without upward ready");
    slot_length_a: assert property ( // [RL18]
        state_q == cmsq_pkg::ST_OVERHEAD |-> ovh_cnt_q < 15'(SLOT_CYCLES))
        else $error("overhead slot did not end");
    settle_used_a: assert property ( // [RL21]
        (state_q == cmsq_pkg::ST_IDLE && start && !adc_ctrl_q.adc_on)
        |=> state_q == cmsq_pkg::ST_SETTLE)
        else $error("settling delay skipped with converter off");
    chan_enabled_a: assert property (seq_slot_done |-> chan_enabled(chan_q, run_cfg_q)) // [RL10]
        else $error("converted a disabled channel");
    ts_clamp_a: assert property ( // [RL3] [RL6]
        seq_slot_done ##0 (chan_q == cmsq_pkg::CH_TS2 && adc_raw_in < cmsq_pkg::TS2_OFFSET)
        |=> res_q[cmsq_pkg::CH_TS2] == 14'h0000)
        else $error("thermistor result below zero not clamped");
    switch_follow_a: assert property (##1 ts1_gnd_switch_out == $past(io_ctrl_q[cmsq_pkg::ADC_TS1_BIT])) // [RL5]
        else $error("ground switch does not follow control bit");
endmodule : cmsq_sequencer
`default_nettype wire

/* cmsq_partner.sv */
// upper stack neighbour and analog source model for the sequencer bench
`timescale 1ns/10ps
`default_nettype none
module cmsq_partner (
    // clock and bench control
    input  wire logic        core_clk_in,
    input  wire logic        hold_ready_in,
    // converter channel select
    input  wire logic [3:0]  adc_chan_in,
    // answers toward the sequencer
    output logic             upward_ready_out,
    output logic      [15:0] adc_raw_out
);
    // neighbour ready, held low on demand to stall the chain
    always_ff @(posedge core_clk_in)
    begin
        upward_ready_out <= !hold_ready_in;
    end
    // raw value per channel; ts2 low and aux high probe both clamp ends
    always_comb
    begin
        case (adc_chan_in)
            4'h7:    adc_raw_out = 16'h0005;
            4'h8:    adc_raw_out = 16'hFFFF;
            default: adc_raw_out = {4'h0, adc_chan_in, 8'h55};
        endcase
    end
endmodule : cmsq_partner
`default_nettype wire

/* cmsq_tb.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int ST = 20;  // shortened settling
    localparam int SL = 8;   // shortened slot
    logic        clk, nrst, wr_s, rd_s, pin, hold, up_rdy, up_st, h_rdy, s_rdy, smp, pwr, rsel, rpk;
    logic        g1, g2, bot;
    logic [5:0]  addr;
    logic [7:0]  wdat, rdat;
    logic [15:0] raw, v;
    logic [3:0]  chan;
    int          n_errors, checks, n, i, n_smp;
    cmsq_sequencer #(.SETTLE_CYCLES(ST), .SLOT_CYCLES(SL)) u_dut (.core_clk_in(clk),
        .nrst_in(nrst), .reg_addr_in(addr), .reg_wdata_in(wdat), .reg_wr_in(wr_s),
        .reg_rd_in(rd_s), .reg_rdata_out(rdat), .host_start_pin_in(pin),
        .south_start_pin_in(1'b0), .upward_result_ready_in(up_rdy), .bottom_device_in(bot),
        .upward_start_out(up_st), .host_result_ready_out(h_rdy),
        .south_result_ready_out(s_rdy), .adc_raw_in(raw), .adc_chan_out(chan),
        .adc_sample_out(smp), .adc_power_out(pwr), .aux_reference_select_out(rsel),
        .aux_source_pack_out(rpk), .ts1_gnd_switch_out(g1), .ts2_gnd_switch_out(g2));
    cmsq_partner u_far (.core_clk_in(clk), .hold_ready_in(hold), .adc_chan_in(chan),
        .upward_ready_out(up_rdy), .adc_raw_out(raw));
    // free-running core clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic end_of_test();
        if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one-cycle write strobe
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    // result pair read, msb byte first at the lower address
    task automatic rd(input logic [5:0] a, output logic [15:0] r);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        addr <= a + 6'h01;
        #1 r[15:8] = rdat;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 r[7:0] = rdat;
    endtask : rd
    // bounded wait for data ready; a hang ends the run
    task automatic wait_rdy();
        n_smp = 0;
        for (n = 0; h_rdy !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
            if (smp === 1'b1)
                n_smp++;
            if (n > 2000)
            begin
                n_errors++;
                end_of_test();
            end
        end
    endtask : wait_rdy
    // software start over all nine channels, cell field above five
    task automatic s_soft();
        wr(6'h30, 8'hF7);  // converter kept on for close cycles
        repeat (ST + 4) @(posedge clk);  // power-up wait scaled
        wr(6'h32, 8'h01);
        rd(6'h32, v);
        chk("software_start_bit bit while running", v[15:8], 16'h0001);
        wait_rdy();
        chk("cycle length", 16'(n >= 10 * SL - 4 && n <= 10 * SL + 6), 16'h0001);
        for (i = 0; i < 6; i++)
        begin
            rd(6'h03 + 6'(2 * i), v);
            chk("cell result", v, {8'(i), 8'h55});
        end
        rd(6'h0F, v);
        chk("ts1 result", v, 16'h0653);
        rd(6'h11, v);
        chk("ts2 result", v, 16'h0000);
        rd(6'h01, v);
        chk("aux result", v, 16'h3FFF);
        rd(6'h32, v);
        chk("software_start_bit bit cleared", v[15:8], 16'h0000);
        rd(6'h20, v);
        chk("unmapped read", v[15:8], 16'h0000);
        chk("power held", pwr, 1'b1);
        chk("sample pulses", 16'(n_smp), 16'h0009);
        chk("channel idle", chan, 16'h000F);
    endtask : s_soft
    // pin start, converter off, software start refused while pin high
    task automatic s_pin();
        wr(6'h30, 8'h00);
        wr(6'h33, 8'h03);
        wr(6'h31, 8'h30);
        @(posedge clk);
        pin <= 1'b1;  // held until cycle ends
        repeat (4) @(posedge clk);
        chk("upward start", up_st, 1'b1);
        chk("ready dropped", h_rdy, 1'b0);
        wait_rdy();
        chk("settle length", 16'(n >= ST + 2 * SL - 6 && n <= ST + 2 * SL + 6), 16'h0001);
        wr(6'h32, 8'h01);
        repeat (ST + 3 * SL) @(posedge clk);
        rd(6'h00, v);
        chk("status idle", v[15:8], 16'h000E);
        chk("aux ref and source", {rsel, rpk}, 16'h0003);
        chk("ground switches", {g1, g2}, 16'h0003);
        @(posedge clk);
        pin <= 1'b0;
        repeat (6) @(posedge clk);
        chk("held start runs", h_rdy, 1'b0);
        wait_rdy();
    endtask : s_pin
    // ready chain gated by the device above
    task automatic s_gate();
        hold <= 1'b1;
        wr(6'h32, 8'h01);  // one device: this write stands for the broadcast
        repeat (ST + 3 * SL) @(posedge clk);
        rd(6'h00, v);
        chk("done flag", v[9], 1'b1);
        chk("ready gated", h_rdy, 1'b0);
        hold <= 1'b0;
        wait_rdy();
        chk("ready follows above", 16'(n <= 5), 16'h0001);
        chk("south ready idle", s_rdy, 1'b0);
        bot <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("south ready", s_rdy, 1'b1);
        chk("host ready off", h_rdy, 1'b0);
    endtask : s_gate
    // reset, then the scenarios
    initial
    begin
        {nrst, wr_s, rd_s, pin, hold, addr, wdat, n_errors, checks} = '0;
        bot = 1'b1;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        s_soft();
        s_pin();
        s_gate();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
